// [include/sotc_pkg.sv]
package sotc_pkg;
    // base clock and counter width
    localparam longint unsigned SOTC_CLK_HZ   = 50_000_000;
    localparam int              SOTC_CW       = 40;
    // times in their own units
    localparam longint unsigned SOTC_WARN_MIN = 30;
    localparam longint unsigned SOTC_TEACH_S  = 10;
    localparam longint unsigned SOTC_POFF_MIN = 5;
    localparam longint unsigned SOTC_INH_MIN  = 10;
    localparam longint unsigned SOTC_TPUL_US  = 250;
    localparam longint unsigned SOTC_TPER_MS  = 100;
    localparam longint unsigned SOTC_BLINK_HZ = 1;
    localparam longint unsigned SOTC_FLASH_HZ = 3;
    localparam longint unsigned SOTC_FLON_MS  = 50;
    localparam longint unsigned SOTC_BLANK_US = 1000;
    localparam longint unsigned SOTC_DISC_MS  = 100;
    // derived cycle counts
    localparam longint unsigned SOTC_WARN_CYC =
        SOTC_WARN_MIN * 60 * SOTC_CLK_HZ;
    localparam longint unsigned SOTC_TEACH_CYC = SOTC_TEACH_S * SOTC_CLK_HZ;
    localparam longint unsigned SOTC_POFF_CYC =
        SOTC_POFF_MIN * 60 * SOTC_CLK_HZ;
    localparam longint unsigned SOTC_INH_CYC = SOTC_INH_MIN * 60 * SOTC_CLK_HZ;
    localparam longint unsigned SOTC_TPUL_CYC =
        (SOTC_TPUL_US * SOTC_CLK_HZ + 999_999) / 1_000_000;
    localparam longint unsigned SOTC_TPER_CYC =
        SOTC_TPER_MS * SOTC_CLK_HZ / 1000;
    localparam longint unsigned SOTC_HALF_CYC =
        SOTC_CLK_HZ / (2 * SOTC_BLINK_HZ);
    localparam longint unsigned SOTC_F3_CYC   = SOTC_CLK_HZ / SOTC_FLASH_HZ;
    localparam longint unsigned SOTC_FLON_CYC =
        SOTC_FLON_MS * SOTC_CLK_HZ / 1000;
    localparam longint unsigned SOTC_BLANK_CYC =
        (SOTC_BLANK_US * SOTC_CLK_HZ + 999_999) / 1_000_000;
    localparam longint unsigned SOTC_DISC_CYC =
        SOTC_DISC_MS * SOTC_CLK_HZ / 1000;
    localparam logic [3:0]      SOTC_REQ_HOLD = 4'h8;
    // response and request byte fields
    localparam int              SOTC_RSP_EN   = 0;
    localparam int              SOTC_RSP_ID   = 1;
    localparam int              SOTC_RSP_IN   = 4;
    localparam int              SOTC_RSP_HYS  = 5;
    localparam int              SOTC_RSP_WARN = 6;
    localparam int              SOTC_RSP_ERR  = 7;
    localparam int              SOTC_REQ_RST  = 7;
    // monitor register map
    localparam logic [3:0]      SOTC_OFS_CTRL = 4'h0;
    localparam logic [3:0]      SOTC_OFS_STAT = 4'h4;
    localparam logic [3:0]      SOTC_OFS_RSP  = 4'h8;
    localparam logic [1:0]      SOTC_OKAY     = 2'h0;
    localparam logic [1:0]      SOTC_SLVERR   = 2'h2;

    typedef enum logic [6:0] {
        ST_BOOT  = 7'h01,
        ST_RUN   = 7'h02,
        ST_TEACH = 7'h04,
        ST_POFF  = 7'h08,
        ST_TFAIL = 7'h10,
        ST_ACTIV = 7'h20,
        ST_INHIB = 7'h40
    } sotc_state_e;
endpackage

// [include/sotc_if.sv]
`timescale 1ns/1ps
interface sotc_if;
    logic       safe_a;
    logic       safe_b;
    logic       diag;
    logic [7:0] rsp;
    logic [7:0] req;

    modport dev (output safe_a, output safe_b, output diag, output rsp,
                 input req);
    modport mon (input safe_a, input safe_b, input diag, input rsp,
                 output req);
endinterface

// [hdl/sotc_sensor.sv]
`timescale 1ns/1ps
// Function
// (R1) actuator gone: both outputs off at once
// (R2) soft fault: warning, diag off, delayed shutdown
// (R3) warning held 30 minutes: outputs off
// (R4) guard open and close clears error
// (R5) request bit 1 then 0 resets fault
// (R6) generic coding works without teach-in
// (R7) teach after power cycle: red on, yellow 1 Hz
// (R8) after 10 s: 3 Hz supply-off request
// (R9) no power-off in 5 min: abort, 5 flashes
// (R10) code activated on redetection, then stored
// (R11) single-teach: pairing permanent, later teach refused
// (R12) multi-teach: repeatable, new code replaces old
// (R13) ten minute output inhibit after learning
// (R14) green flashes until inhibit over and detected
// (R15) power loss restarts whole inhibit interval
// (R16) periodic short off-pulse on each output
// (R17) monitor ignores roughly 1 ms test pulses
// (R18) monitor allows 100 ms channel discrepancy
// (R19) monitor has no cross-wire check
// (R20) monitor takes high-side normally-open inputs
// (R21) yellow steady on detect, flashing in hysteresis
// (R22) response byte reports status in bits 0, 1 and 4..7
// (R23) all intervals from internal counters, reset cleared
module sotc_sensor
    import sotc_pkg::*;
#(
    parameter longint unsigned WARN_CYC  = SOTC_WARN_CYC,
    parameter longint unsigned TEACH_CYC = SOTC_TEACH_CYC,
    parameter longint unsigned POFF_CYC  = SOTC_POFF_CYC,
    parameter longint unsigned INH_CYC   = SOTC_INH_CYC,
    parameter longint unsigned TPUL_CYC  = SOTC_TPUL_CYC,
    parameter longint unsigned TPER_CYC  = SOTC_TPER_CYC,
    parameter longint unsigned HALF_CYC  = SOTC_HALF_CYC,
    parameter longint unsigned F3_CYC    = SOTC_F3_CYC,
    parameter longint unsigned FLON_CYC  = SOTC_FLON_CYC
) (
    // clock and reset
    input  logic sys_clk_in,
    input  logic srst_in,
    // link toward monitor and gateway
    sotc_if.dev  lnk,
    // variant straps, caught after reset release
    input  logic generic_coding_in,
    input  logic single_teach_variant_in,
    input  logic serial_diagnostic_variant_in,
    // nonvolatile teach record
    input  logic nv_pending_in,
    input  logic nv_inhibit_in,
    input  logic nv_paired_in,
    output logic nv_pending_out,
    output logic nv_inhibit_out,
    output logic code_store_out,
    // sensing front end
    input  logic act_present_in,
    input  logic act_match_in,
    input  logic hyst_zone_in,
    input  logic fault_in,
    input  logic safe_in_a_in,
    input  logic safe_in_b_in,
    // indicators
    output logic led_green_out,
    output logic led_red_out,
    output logic led_yellow_out
);
    typedef struct packed {
        sotc_state_e        st;
        logic [5:0]         s1;
        logic [5:0]         s2;
        logic               generic;
        logic               single;
        logic               serial;
        logic               seen;
        logic               warn;
        logic               err;
        logic               opened;
        logic               req7;
        logic               b1;
        logic [2:0]         idx;
        logic [SOTC_CW-1:0] tmr;
        logic [SOTC_CW-1:0] wtmr;
        logic [SOTC_CW-1:0] tper;
        logic [SOTC_CW-1:0] blk;
        logic [SOTC_CW-1:0] f3;
        logic               sa;
        logic               sb;
        logic               diag;
        logic               grn;
        logic               red;
        logic               yel;
        logic               store;
        logic [7:0]         rsp;
    } sotc_dev_s;

    localparam sotc_dev_s DEV_RST = '{st: ST_BOOT, default: '0};

    sotc_dev_s q_q;
    sotc_dev_s q_d;

    logic pres;
    logic match;
    logic hyst;
    logic flt;
    logic inboth;
    logic idok;
    logic en;
    logic pa;
    logic pb;
    logic fl3;

    assign pres   = q_q.s2[5];
    assign match  = q_q.s2[4];
    assign hyst   = q_q.s2[3];
    assign flt    = q_q.s2[2];
    assign inboth = q_q.s2[1] & q_q.s2[0];
    assign idok   = pres & (q_q.generic | match); // R6
    assign en     = (q_q.st == ST_RUN) & idok & ~q_q.err; // R1 R13
    assign pa     = q_q.tper < SOTC_CW'(TPUL_CYC); // R16
    assign pb     = (q_q.tper >= SOTC_CW'(TPER_CYC / 2)) &
                    (q_q.tper < SOTC_CW'(TPER_CYC / 2 + TPUL_CYC)); // R16
    assign fl3    = q_q.f3 < SOTC_CW'(FLON_CYC);

    always_comb begin
        q_d       = q_q;
        q_d.store = 1'b0;
        q_d.s1    = {act_present_in, act_match_in, hyst_zone_in, fault_in,
                     safe_in_a_in, safe_in_b_in};
        q_d.s2    = q_q.s1;
        q_d.req7  = lnk.req[SOTC_REQ_RST];

        // free-running time bases
        if (q_q.tper >= SOTC_CW'(TPER_CYC - 1)) begin
            q_d.tper = '0;
        end else begin
            q_d.tper = q_q.tper + 1'b1;
        end
        if (q_q.blk >= SOTC_CW'(HALF_CYC - 1)) begin
            q_d.blk = '0;
            q_d.b1  = ~q_q.b1;
            if (q_q.b1) begin
                q_d.idx = q_q.idx + 3'd1;
            end
        end else begin
            q_d.blk = q_q.blk + 1'b1;
        end
        if (q_q.f3 >= SOTC_CW'(F3_CYC - 1)) begin
            q_d.f3 = '0;
        end else begin
            q_d.f3 = q_q.f3 + 1'b1;
        end

        // soft fault warning and delayed shutdown
        if (flt && !q_q.err) begin
            q_d.warn = 1'b1; // R2
            if (q_q.wtmr >= SOTC_CW'(WARN_CYC - 1)) begin
                q_d.err  = 1'b1; // R3
                q_d.warn = 1'b0;
            end else begin
                q_d.wtmr = q_q.wtmr + 1'b1; // R23
            end
        end else if (!q_q.err) begin
            q_d.warn = 1'b0;
            q_d.wtmr = '0;
        end
        // error is only left once its cause has gone
        if (q_q.err && !flt) begin
            if (!pres) begin
                q_d.opened = 1'b1;
            end
            if (q_q.opened && pres) begin
                q_d.err    = 1'b0; // R4
                q_d.opened = 1'b0;
                q_d.wtmr   = '0;
            end
            if (q_q.serial && q_q.req7 && !lnk.req[SOTC_REQ_RST]) begin
                q_d.err    = 1'b0; // R5
                q_d.opened = 1'b0;
                q_d.wtmr   = '0;
            end
        end

        if (pres) begin
            q_d.seen = 1'b1;
        end

        case (q_q.st)
            ST_BOOT: begin
                q_d.generic = generic_coding_in;
                q_d.single  = single_teach_variant_in;
                q_d.serial  = serial_diagnostic_variant_in;
                q_d.tmr     = '0;
                if (generic_coding_in) begin
                    q_d.st = ST_RUN; // R6
                end else if (nv_inhibit_in) begin
                    q_d.st = ST_INHIB; // R15
                end else if (nv_pending_in) begin
                    q_d.st = ST_ACTIV;
                end else begin
                    q_d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                // teach only on first arrival after a power cycle
                if (!q_q.generic && pres && !match && !q_q.seen &&
                    !(q_q.single && nv_paired_in)) begin // R11 R12
                    q_d.st  = ST_TEACH; // R7
                    q_d.tmr = '0;
                end
            end
            ST_TEACH: begin
                if (q_q.tmr >= SOTC_CW'(TEACH_CYC - 1)) begin
                    q_d.st  = ST_POFF; // R8
                    q_d.tmr = '0;
                end else begin
                    q_d.tmr = q_q.tmr + 1'b1;
                end
            end
            ST_POFF: begin
                if (q_q.tmr >= SOTC_CW'(POFF_CYC - 1)) begin
                    q_d.st  = ST_TFAIL; // R9
                    q_d.tmr = '0;
                end else begin
                    q_d.tmr = q_q.tmr + 1'b1;
                end
            end
            ST_TFAIL: begin
                q_d.st = ST_TFAIL;
            end
            ST_ACTIV: begin
                if (pres) begin
                    q_d.store = 1'b1; // R10 R12
                    q_d.st    = ST_INHIB; // R13
                    q_d.tmr   = '0;
                end
            end
            ST_INHIB: begin
                if (q_q.tmr < SOTC_CW'(INH_CYC)) begin
                    q_d.tmr = q_q.tmr + 1'b1; // R13
                end else if (pres && match) begin
                    q_d.st = ST_RUN; // R14
                end
            end
            default: begin
                q_d.st = ST_BOOT;
            end
        endcase

        // outputs, registered
        q_d.sa   = en & ~pa; // R1 R16
        q_d.sb   = en & ~pb; // R1 R16
        q_d.diag = en & ~q_q.warn & ~(hyst & ~q_q.b1); // R2
        case (q_q.st)
            ST_TEACH: begin
                q_d.grn = 1'b0;
                q_d.red = 1'b1; // R7
                q_d.yel = q_q.b1; // R7
            end
            ST_POFF: begin
                q_d.grn = 1'b0;
                q_d.red = 1'b1;
                q_d.yel = fl3; // R8
            end
            ST_TFAIL: begin
                q_d.grn = 1'b0;
                q_d.red = q_q.b1 & (q_q.idx < 3'd5); // R9
                q_d.yel = pres;
            end
            ST_INHIB: begin
                q_d.grn = q_q.b1; // R14
                q_d.red = 1'b0;
                q_d.yel = 1'b0;
            end
            default: begin
                q_d.grn = ~(q_q.warn | q_q.err);
                q_d.red = (q_q.warn | q_q.err) & q_q.b1;
                q_d.yel = pres & (~hyst | q_q.b1); // R21
            end
        endcase
        q_d.rsp = '0;
        if (q_q.serial) begin
            q_d.rsp[SOTC_RSP_EN]   = en; // R22
            q_d.rsp[SOTC_RSP_ID]   = idok;
            q_d.rsp[SOTC_RSP_IN]   = inboth;
            q_d.rsp[SOTC_RSP_HYS]  = pres & hyst;
            q_d.rsp[SOTC_RSP_WARN] = q_q.warn;
            q_d.rsp[SOTC_RSP_ERR]  = q_q.err;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            q_q <= DEV_RST; // R23
        end else begin
            q_q <= q_d;
        end
    end

    assign lnk.safe_a     = q_q.sa;
    assign lnk.safe_b     = q_q.sb;
    assign lnk.diag       = q_q.diag;
    assign lnk.rsp        = q_q.rsp;
    assign nv_pending_out = q_q.st[3];
    assign nv_inhibit_out = q_q.st[6];
    assign code_store_out = q_q.store;
    assign led_green_out  = q_q.grn;
    assign led_red_out    = q_q.red;
    assign led_yellow_out = q_q.yel;
endmodule // sotc_sensor

// [hdl/sotc_monitor.sv]
`timescale 1ns/1ps
module sotc_monitor
    import sotc_pkg::*;
#(
    parameter longint unsigned BLANK_CYC = SOTC_BLANK_CYC,
    parameter longint unsigned DISC_CYC  = SOTC_DISC_CYC
) (
    // clock and reset
    input  logic        sys_clk_in,
    input  logic        srst_in,
    // link toward sensor
    sotc_if.mon         lnk,
    // axi4-lite slave
    input  logic [3:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    input  logic [3:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    // safety relay drive
    output logic        release_out
);
    typedef struct packed {
        logic [1:0][SOTC_CW-1:0] lo;
        logic [1:0]              on;
        logic [SOTC_CW-1:0]      dc;
        logic                    lock;
        logic                    rel;
        logic [3:0]              hold;
        logic                    aw;
        logic [3:0]              awa;
        logic                    w;
        logic [31:0]             wd;
        logic [3:0]              ws;
        logic                    bv;
        logic [1:0]              br;
        logic                    rv;
        logic [31:0]             rd;
        logic [1:0]              rr;
    } sotc_mon_s;

    sotc_mon_s q_q;
    sotc_mon_s q_d;
    logic [1:0] pin;

    assign pin = {lnk.safe_b, lnk.safe_a};

    always_comb begin
        q_d = q_q;
        // high means channel closed; short lows are test pulses
        for (int i = 0; i < 2; i++) begin
            if (pin[i]) begin
                q_d.lo[i] = '0; // R20
                q_d.on[i] = 1'b1;
            end else if (q_q.lo[i] >= SOTC_CW'(BLANK_CYC - 1)) begin
                q_d.on[i] = 1'b0; // R17
            end else begin
                q_d.lo[i] = q_q.lo[i] + 1'b1;
            end
        end
        // no cross-wire test: both channels are evaluated apart
        if (q_q.on[0] != q_q.on[1]) begin // R19
            if (q_q.dc >= SOTC_CW'(DISC_CYC - 1)) begin
                q_d.lock = 1'b1; // R18
            end else begin
                q_d.dc = q_q.dc + 1'b1;
            end
        end else begin
            q_d.dc = '0;
            if (!q_q.on[0]) begin
                q_d.lock = 1'b0;
            end
        end
        q_d.rel = q_q.on[0] & q_q.on[1] & ~q_q.lock;
        if (q_q.hold != 4'h0) begin
            q_d.hold = q_q.hold - 4'h1;
        end

        // write channel, address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            q_d.aw  = 1'b1;
            q_d.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            q_d.w  = 1'b1;
            q_d.wd = s_axi_wdata;
            q_d.ws = s_axi_wstrb;
        end
        if (q_q.aw && q_q.w) begin
            q_d.aw = 1'b0;
            q_d.w  = 1'b0;
            q_d.bv = 1'b1;
            q_d.br = SOTC_OKAY;
            if (q_q.awa == SOTC_OFS_CTRL) begin
                if (q_q.ws[0] && q_q.wd[0]) begin
                    q_d.hold = SOTC_REQ_HOLD; // R5
                end
            end else if (q_q.awa != SOTC_OFS_STAT &&
                         q_q.awa != SOTC_OFS_RSP) begin
                q_d.br = SOTC_SLVERR;
            end
        end
        if (q_q.bv && s_axi_bready) begin
            q_d.bv = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            q_d.rv = 1'b1;
            q_d.rr = SOTC_OKAY;
            q_d.rd = '0;
            case (s_axi_araddr)
                SOTC_OFS_CTRL: q_d.rd[0] = q_q.hold != 4'h0;
                SOTC_OFS_STAT: q_d.rd[5:0] = {lnk.diag, q_q.on, q_q.lock,
                                              q_q.rel, 1'b0};
                SOTC_OFS_RSP:  q_d.rd[7:0] = lnk.rsp;
                default:       q_d.rr = SOTC_SLVERR;
            endcase
        end else if (q_q.rv && s_axi_rready) begin
            q_d.rv = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign s_axi_awready = ~q_q.aw & ~q_q.bv;
    assign s_axi_wready  = ~q_q.w & ~q_q.bv;
    assign s_axi_bvalid  = q_q.bv;
    assign s_axi_bresp   = q_q.br;
    assign s_axi_arready = ~q_q.rv;
    assign s_axi_rvalid  = q_q.rv;
    assign s_axi_rdata   = q_q.rd;
    assign s_axi_rresp   = q_q.rr;
    assign lnk.req       = {q_q.hold != 4'h0, 7'h00};
    assign release_out   = q_q.rel;
endmodule // sotc_monitor

// [dv/sotc_link_sva.sv]
`timescale 1ns/1ps
module sotc_link_sva
    import sotc_pkg::*;
#(
    parameter longint unsigned TPER_CYC = SOTC_TPER_CYC
) (
    // clock and reset
    input  logic       sys_clk_in,
    input  logic       srst_in,
    // link signals
    input  logic       safe_a,
    input  logic       safe_b,
    input  logic       diag,
    input  logic [7:0] rsp,
    input  logic [7:0] req
);
    logic [15:0] hi_a_q;

    // a missing test pulse shows up as an overlong high run
    always_ff @(posedge sys_clk_in) begin
        if (srst_in || !safe_a) begin
            hi_a_q <= 16'h0000;
        end else begin
            hi_a_q <= hi_a_q + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    a_req_hold: assert property ($rose(req[SOTC_REQ_RST]) |->
        req[SOTC_REQ_RST] [*8] ##1 !req[SOTC_REQ_RST])
        else $error("fault reset request length wrong");
    a_err_diag: assert property (rsp[SOTC_RSP_ERR] |-> !diag)
        else $error("diagnostic output on during error");
    a_pulse_a: assert property ($fell(safe_a) && safe_b |-> !safe_a [*3])
        else $error("channel a test pulse too short");
    a_pulse_b: assert property ($fell(safe_b) && safe_a |-> !safe_b [*3])
        else $error("channel b test pulse too short");
    a_pulse_period: assert property (hi_a_q < 16'(TPER_CYC))
        else $error("channel a missed its test pulse");
    a_err_off: assert property (rsp[SOTC_RSP_ERR] &&
        $past(rsp[SOTC_RSP_ERR]) |-> !safe_a && !safe_b)
        else $error("outputs on while error reported");
    a_warn_diag: assert property (rsp[SOTC_RSP_WARN] &&
        $past(rsp[SOTC_RSP_WARN]) |-> !diag)
        else $error("diagnostic output on during warning");
    a_rsp_en: assert property (rsp[SOTC_RSP_EN] |-> safe_a || safe_b)
        else $error("outputs reported enabled while both off");

    c_req: cover property ($rose(req[SOTC_REQ_RST]));
    c_pulse: cover property ($fell(safe_a) && safe_b);
    c_err: cover property (rsp[SOTC_RSP_ERR]);
endmodule // sotc_link_sva

// [dv/test_safety_output_teach_control.sv]
`timescale 1ns/1ps
module test_safety_output_teach_control;
    import sotc_pkg::*;
    // shortened counts keep the run under two thousand cycles
    localparam longint unsigned WARN = 200, TEACH = 50, POFF = 100;
    localparam longint unsigned INH = 80, TPER = 40, TPUL = 3, HALF = 4;
    localparam longint unsigned F3 = 6, FLON = 2, BLANK = 5, DISC = 20;
    logic        clk = 1'h0, srst = 1'h1;
    logic        gen = 1'h0, sgl = 1'h0, pend = 1'h0, inh = 1'h0;
    logic        paired = 1'h0, pres = 1'h0, match = 1'h0;
    logic        hyst = 1'h0, fault = 1'h0, ser = 1'h1;
    logic        nvp, nvi, store, grn, red, yel, rel;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [5:0]  s1, s0;
    int          n_errors = 0, tests_run = 0;

    always #10 clk = ~clk;

    sotc_if lnk_if ();
    sotc_sensor #(.WARN_CYC(WARN), .TEACH_CYC(TEACH), .POFF_CYC(POFF),
        .INH_CYC(INH), .TPUL_CYC(TPUL), .TPER_CYC(TPER), .HALF_CYC(HALF),
        .F3_CYC(F3), .FLON_CYC(FLON)) sotc_sensor_i (
        .sys_clk_in(clk), .srst_in(srst), .lnk(lnk_if.dev),
        .generic_coding_in(gen), .single_teach_variant_in(sgl),
        .serial_diagnostic_variant_in(ser), .nv_pending_in(pend),
        .nv_inhibit_in(inh), .nv_paired_in(paired), .nv_pending_out(nvp),
        .nv_inhibit_out(nvi), .code_store_out(store),
        .act_present_in(pres), .act_match_in(match), .hyst_zone_in(hyst),
        .fault_in(fault), .safe_in_a_in(1'h1), .safe_in_b_in(1'h1),
        .led_green_out(grn), .led_red_out(red), .led_yellow_out(yel));
    sotc_monitor #(.BLANK_CYC(BLANK), .DISC_CYC(DISC)) sotc_monitor_i (
        .sys_clk_in(clk), .srst_in(srst), .lnk(lnk_if.mon),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .release_out(rel));
    sotc_link_sva #(.TPER_CYC(TPER)) sotc_link_sva_i (
        .sys_clk_in(clk), .srst_in(srst), .safe_a(lnk_if.safe_a),
        .safe_b(lnk_if.safe_b), .diag(lnk_if.diag), .rsp(lnk_if.rsp),
        .req(lnk_if.req));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // straps are caught only at reset release, so each variant reboots
    task automatic boot(input logic g, input logic s, input logic p,
                        input logic i);
        @(posedge clk);
        srst <= 1'h1;
        gen <= g;
        sgl <= s;
        pend <= p;
        inh <= i;
        pres <= 1'h0;
        match <= 1'h0;
        fault <= 1'h0;
        cyc(12);
        srst <= 1'h0;
        cyc(3);
    endtask

    // bits seen high and low: release, safe a, safe b, green, red, yellow
    task automatic watch(input int n);
        logic [5:0] v;
        s1 = 6'h00;
        s0 = 6'h00;
        repeat (n) begin
            @(posedge clk);
            v = {rel, lnk_if.safe_a, lnk_if.safe_b, grn, red, yel};
            s1 |= v;
            s0 |= ~v;
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk);
        awaddr <= a;
        wdata <= wd;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask

    task automatic t_run;
        boot(1'h1, 1'h0, 1'h0, 1'h0);
        pres <= 1'h1;
        match <= 1'h1;
        cyc(10);
        watch(2 * TPER);
        chk(s0[5], 1'h0);
        chk(s0[0], 1'h0);
        chk(s0[4:3], 2'h3);
        axi_rd(SOTC_OFS_RSP);
        chk(d[7:0] & 8'hf3, 8'h13);
        axi_rd(SOTC_OFS_STAT);
        chk(d[5:0], 6'h3a);
        hyst <= 1'h1;
        watch(12);
        chk(s1[0] & s0[0], 1'h1);
        hyst <= 1'h0;
        pres <= 1'h0;
        cyc(3);
        #1;
        chk({lnk_if.safe_a, lnk_if.safe_b}, 2'h0);
    endtask
    task automatic t_warn;
        @(posedge clk);
        pres <= 1'h1;
        cyc(10);
        chk(lnk_if.diag, 1'h1);
        fault <= 1'h1;
        cyc(6);
        axi_rd(SOTC_OFS_RSP);
        chk(lnk_if.diag, 1'h0);
        chk({d[7:6], d[0]}, 3'h3);
        cyc(WARN - 40);
        axi_rd(SOTC_OFS_RSP);
        chk({d[7], d[0]}, 2'h1);
        cyc(40);
        axi_rd(SOTC_OFS_RSP);
        chk({d[7], d[0]}, 2'h2);
        fault <= 1'h0;
        cyc(10);
        axi_rd(SOTC_OFS_RSP);
        chk(d[7], 1'h1);
        pres <= 1'h0;
        cyc(10);
        pres <= 1'h1;
        cyc(10);
        axi_rd(SOTC_OFS_RSP);
        chk({d[7], d[0]}, 2'h1);
    endtask
    task automatic t_sdrst;
        @(posedge clk);
        fault <= 1'h1;
        cyc(WARN + 20);
        fault <= 1'h0;
        cyc(5);
        axi_rd(SOTC_OFS_RSP);
        chk(d[7], 1'h1);
        axi_wr(SOTC_OFS_CTRL, 32'h0000_0001);
        chk(r, SOTC_OKAY);
        cyc(16);
        axi_rd(SOTC_OFS_RSP);
        chk({d[7], d[0]}, 2'h1);
        axi_rd(4'hc);
        chk({r, d[15:0]}, {SOTC_SLVERR, 16'h0000});
        axi_wr(SOTC_OFS_STAT, 32'hffff_ffff);
        chk(r, SOTC_OKAY);
    endtask

    task automatic t_teach;
        boot(1'h0, 1'h0, 1'h0, 1'h0);
        pres <= 1'h1;
        cyc(6);
        watch(12);
        chk({s0[1], s1[0] & s0[0]}, 2'h1);
        chk(nvp, 1'h0);
        cyc(TEACH);
        chk(nvp, 1'h1);
        cyc(POFF + 10);
        watch(40);
        chk(nvp, 1'h0);
        chk({s1[4:3], s1[1] & s0[1]}, 3'h1);
    endtask

    task automatic t_learn;
        int k;
        boot(1'h0, 1'h0, 1'h1, 1'h0);
        pres <= 1'h1;
        match <= 1'h1;
        k = 0;
        repeat (10) begin
            @(posedge clk);
            if (store === 1'h1) k++;
        end
        chk(k, 1);
        chk(nvi, 1'h1);
        watch(20);
        chk({s1[4:3], s1[2] & s0[2]}, 3'h1);
        cyc(INH);
        watch(10);
        chk({nvi, s0[2], s1[4]}, 3'h1);
        boot(1'h0, 1'h0, 1'h0, 1'h1);
        pres <= 1'h1;
        match <= 1'h1;
        cyc(INH - 20);
        chk({nvi, lnk_if.safe_a}, 2'h2);
        cyc(40);
        chk(nvi, 1'h0);
    endtask

    task automatic t_variant;
        for (int i = 0; i < 2; i++) begin
            paired <= 1'h1;
            ser <= i[0];
            boot(1'h0, i == 0, 1'h0, 1'h0);
            pres <= 1'h1;
            cyc(TEACH + 10);
            chk(nvp, i);
            chk(lnk_if.rsp, {i[0], 4'h0});
        end
        paired <= 1'h0;
    endtask

    initial begin
        t_run;
        t_warn;
        t_sdrst;
        t_teach;
        t_learn;
        t_variant;
        end_sim;
    end

    // scenarios take about 1300 cycles
    initial begin
        repeat (6000) @(posedge clk);
        n_errors++;
        end_sim;
    end
endmodule // test_safety_output_teach_control
